// [hdl/irqlv_top.sv]
// Interrupt flags, enables, grouping and low supply monitor of a small controller.
// Assumes the core drives the 8-bit special register port and acknowledges vectors.
`timescale 1ns/1ns
`default_nettype none

module irqlv_top
#(
  parameter int unsigned MONITOR_DELAY_CYC = irqlv_pkg::MONITOR_IRQ_DELAY_CYC
)
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic [2:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic [1:0]  external_irq_pin_i,
  input  wire logic [1:0]  comparator_evt_i,
  input  wire logic [1:0]  time_base_evt_i,
  input  wire logic        adc_evt_i,
  input  wire logic        usim_evt_i,
  input  wire logic        uart_evt_i,
  input  wire logic [3:0]  timer_group0_evt_i,
  input  wire logic [1:0]  timer_group1_evt_i,
  input  wire logic        eeprom_evt_i,
  input  wire logic        supply_below_i,
  input  wire logic        sleep_i,
  input  wire logic        idle_i,
  input  wire logic        irq_ack_i,
  output logic             irq_req_o,
  output logic      [3:0]  irq_vector_o,
  output logic             wake_o,
  output logic             supply_monitor_on_o,
  output logic      [11:0] supply_threshold_mv_o
);

  localparam int unsigned NR = irqlv_pkg::NUM_REGS;
  localparam int unsigned NS = irqlv_pkg::NUM_SRC;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic reg_hit(input logic [2:0] addr, input int unsigned idx);
    reg_hit = (addr == 3'(idx));
  endfunction : reg_hit

  function automatic logic group_any(input logic [7:0] r);
    group_any = |(r[irqlv_pkg::SUB_FLAG_LSB +: 4] & r[irqlv_pkg::SUB_EN_LSB +: 4]);
  endfunction : group_any

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]    reg_q [NR];
  logic [7:0]    reg_d [NR];
  logic [7:0]    set_v [NR];
  logic [7:0]    clr_v [NR];
  logic [1:0]    pin_edge;
  logic          low_supply_flag;
  logic          low_supply_irq;
  logic          monitor_on;
  logic [NS-1:0] src_flag;
  logic [NS-1:0] src_en;
  logic [NS-1:0] src_pend;
  logic          any_pend;
  logic [3:0]    pend_vec;
  logic          new_flag;
  logic [7:0]    rdata;

  // ************************************************************
  // External pin edge detectors
  // ************************************************************
  // Pins must arrive already synchronised.
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    irqlv_edge_detect u_edge
    (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .pin_i    (external_irq_pin_i[p]),
      .sel_i    (reg_q[irqlv_pkg::REG_EDGE][2*p +: 2]),
      .edge_o   (pin_edge[p])
    );
  end

  // ************************************************************
  // Supply monitor
  // ************************************************************
  // Sleep overrides the enable in here.
  irqlv_supply_monitor
  #(
    .DELAY_CYC (MONITOR_DELAY_CYC)
  )
  u_monitor
  (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .enable_i (reg_q[irqlv_pkg::REG_MONITOR][irqlv_pkg::MON_EN_BIT]),
    .sleep_i  (sleep_i),
    .below_i  (supply_below_i),
    .on_o     (monitor_on),
    .flag_o   (low_supply_flag),
    .irq_o    (low_supply_irq)
  );

  // ************************************************************
  // Hardware set events
  // ************************************************************
  always_comb
  begin
    for (int i = 0; i < NR; i++)
    begin
      set_v[i] = 8'h00;
    end
    // Event inputs are one-cycle pulses.
    set_v[irqlv_pkg::REG_PRIM0][4] = pin_edge[0];
    set_v[irqlv_pkg::REG_PRIM0][5] = comparator_evt_i[0];
    set_v[irqlv_pkg::REG_PRIM0][6] = group_any(reg_q[irqlv_pkg::REG_GROUP0]);
    set_v[irqlv_pkg::REG_PRIM1][4] = group_any(reg_q[irqlv_pkg::REG_GROUP1]);
    set_v[irqlv_pkg::REG_PRIM1][5] = adc_evt_i;
    set_v[irqlv_pkg::REG_PRIM1][6] = time_base_evt_i[0];
    set_v[irqlv_pkg::REG_PRIM1][7] = time_base_evt_i[1];
    set_v[irqlv_pkg::REG_PRIM2][4] = pin_edge[1];
    set_v[irqlv_pkg::REG_PRIM2][5] = comparator_evt_i[1];
    set_v[irqlv_pkg::REG_PRIM2][6] = usim_evt_i;
    set_v[irqlv_pkg::REG_PRIM2][7] = uart_evt_i;
    set_v[irqlv_pkg::REG_GROUP0][7:4] = timer_group0_evt_i;
    set_v[irqlv_pkg::REG_GROUP1][5:4] = timer_group1_evt_i;
    set_v[irqlv_pkg::REG_GROUP1][irqlv_pkg::LOWSUP_FLAG_BIT] = low_supply_irq;
    set_v[irqlv_pkg::REG_GROUP1][7] = eeprom_evt_i;
  end

  // ************************************************************
  // Acknowledge clears the flag of the vector being serviced
  // ************************************************************
  always_comb
  begin
    // Sub-flags are left for software.
    for (int i = 0; i < NR; i++)
    begin
      clr_v[i] = 8'h00;
    end
    for (int k = 0; k < NS; k++)
    begin
      if (irq_ack_i && irq_req_o && irq_vector_o == 4'(k))
      begin
        clr_v[irqlv_pkg::SRC_REG[k]][irqlv_pkg::SRC_FLAG[k]] = 1'b1;
      end
    end
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  // A hardware set in the same cycle as a software or acknowledge clear wins,
  // so an event arriving during the clear is never lost.
  for (genvar r = 0; r < NR; r++)
  begin : g_reg
    always_comb
    begin
      reg_d[r] = reg_q[r];
      if (sfr_wr_i && reg_hit(sfr_addr_i, r))
      begin
        reg_d[r] = (sfr_wdata_i & irqlv_pkg::WMASK[r]) | (reg_q[r] & ~irqlv_pkg::WMASK[r]);
      end
      reg_d[r] = (reg_d[r] & ~clr_v[r]) | set_v[r];
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        reg_q[r] <= irqlv_pkg::REG_RESET;
      end
      else
      begin
        reg_q[r] <= reg_d[r];
      end
    end
  end

  // ************************************************************
  // Pending sources and priority
  // ************************************************************
  // Vector order lives in the package.
  for (genvar k = 0; k < NS; k++)
  begin : g_src
    assign src_flag[k] = reg_q[irqlv_pkg::SRC_REG[k]][irqlv_pkg::SRC_FLAG[k]];
    assign src_en[k]   = reg_q[irqlv_pkg::SRC_REG[k]][irqlv_pkg::SRC_EN[k]];
    assign src_pend[k] = src_flag[k] & src_en[k];
  end

  // Lowest vector number is serviced first.
  always_comb
  begin
    pend_vec = 4'h0;
    for (int k = NS - 1; k >= 0; k--)
    begin
      if (src_pend[k])
      begin
        pend_vec = 4'(k);
      end
    end
  end

  // Flags still latch while global is off.
  assign any_pend = (|src_pend) & reg_q[irqlv_pkg::REG_PRIM0][irqlv_pkg::GLOBAL_EN_BIT];

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_req_o    <= 1'b0;
      irq_vector_o <= 4'h0;
    end
    else
    begin
      irq_req_o    <= any_pend;
      irq_vector_o <= pend_vec;
    end
  end

  // ************************************************************
  // Wake-up
  // ************************************************************
  // Only a flag going from clear to set wakes the device, which lets software
  // mask a wake source by setting its flag beforehand.
  always_comb
  begin
    new_flag = 1'b0;
    for (int i = 0; i < NR; i++)
    begin
      new_flag = new_flag | (|(set_v[i] & ~reg_q[i] & 8'hf0));
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wake_o <= 1'b0;
    end
    else
    begin
      wake_o <= (sleep_i | idle_i) & new_flag;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_comb
  begin
    rdata = 8'h00;
    for (int i = 0; i < NR; i++)
    begin
      if (reg_hit(sfr_addr_i, i))
      begin
        rdata = reg_q[i] & irqlv_pkg::WMASK[i];
      end
    end
    // The live flag bit is never stored.
    if (reg_hit(sfr_addr_i, irqlv_pkg::REG_MONITOR))
    begin
      rdata[irqlv_pkg::MON_FLAG_BIT] = low_supply_flag;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    // Data holds so the core may read late.
    if (!resetn_i)
    begin
      sfr_rdata_o <= 8'h00;
    end
    else if (sfr_rd_i)
    begin
      sfr_rdata_o <= rdata;
    end
  end

  // ************************************************************
  // Analog side of the supply monitor
  // ************************************************************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      supply_monitor_on_o   <= 1'b0;
      supply_threshold_mv_o <= irqlv_pkg::THRESH_MV[0];
    end
    else
    begin
      supply_monitor_on_o   <= monitor_on;
      // The lag is far below analog settling.
      supply_threshold_mv_o <= irqlv_pkg::THRESH_MV[reg_q[irqlv_pkg::REG_MONITOR][2:0]];
    end
  end

endmodule : irqlv_top
`default_nettype wire

// [inc/irqlv_pkg.sv]
// Constants, register layout and state types of the interrupt and supply monitor block.
// Assumes a single 25 MHz clock and an 8-bit special register port driven by the core.
//
// Summary of operation
// - Low supply flag rises when supply drops below the selected 1.8V to 4.0V threshold.
// - Entering sleep forces the supply monitor off even with its enable set.
// - The low supply flag is not filtered and may toggle near the threshold.
// - The low supply request belongs to multi-function group 1, not a primary line.
// - The low supply request is raised only after a fixed delay past the flag rising.
// - In idle the monitor keeps running; a supply drop sets its flag and wakes.
// - Two external pins, 0 and 1, each have an enable and a request flag.
// - Every source has a writable enable bit and a flag set by hardware.
// - Three primary control registers and two grouped registers feeding the group requests.
// - Pin 1 edge select at bits 3..2: off, rising, falling, both.
// - Pin 0 edge select at bits 1..0 uses the same coding.
// - Bits 7..4 of the edge select register always read as zero.
// - Bit 6 of primary control zero is the group 0 request flag.
// - Bit 5 of primary control zero is the comparator 0 request flag.
// - Bit 4 of primary control zero is pin 0 flag, bit 1 its enable.
// - An enabled pending source requests the core and presents its vector while global enable, bit 0 of primary control zero, is set.
// - A newly set request flag wakes the device from sleep or idle.

package irqlv_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned NUM_REGS    = 7;
  localparam logic [2:0]  REG_MONITOR = 3'h0;
  localparam logic [2:0]  REG_EDGE    = 3'h1;
  localparam logic [2:0]  REG_PRIM0   = 3'h2;
  localparam logic [2:0]  REG_PRIM1   = 3'h3;
  localparam logic [2:0]  REG_PRIM2   = 3'h4;
  localparam logic [2:0]  REG_GROUP0  = 3'h5;
  localparam logic [2:0]  REG_GROUP1  = 3'h6;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // Writable bits of each register; the rest read as zero or as live state.
  localparam logic [7:0] WMASK [NUM_REGS] = '{8'h17, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned MON_FLAG_BIT  = 5;
  localparam int unsigned MON_EN_BIT    = 4;
  localparam int unsigned MON_SEL_LSB   = 0;
  localparam int unsigned PIN1_SEL_LSB  = 2;
  localparam int unsigned PIN0_SEL_LSB  = 0;
  localparam int unsigned GLOBAL_EN_BIT = 0;
  localparam int unsigned SUB_FLAG_LSB  = 4;
  localparam int unsigned SUB_EN_LSB    = 0;
  localparam int unsigned LOWSUP_FLAG_BIT = 6;

  // Edge select coding.
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ************************************************************
  // Primary sources in vector order: pin0, comparator0, group0, adc, time base 0,
  // time base 1, group1, pin1, comparator1, usim, uart.
  // ************************************************************
  localparam int unsigned NUM_SRC = 11;
  localparam logic [2:0] SRC_REG [NUM_SRC] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
                                               3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
  localparam logic [2:0] SRC_FLAG [NUM_SRC] = '{3'h4, 3'h5, 3'h6, 3'h5, 3'h6, 3'h7,
                                                3'h4, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [2:0] SRC_EN [NUM_SRC] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3,
                                              3'h0, 3'h0, 3'h1, 3'h2, 3'h3};

  // ************************************************************
  // Supply thresholds in millivolts, indexed by the threshold select field
  // ************************************************************
  localparam logic [11:0] THRESH_MV [8] = '{12'h708, 12'h7d0, 12'h960, 12'ha8c,
                                            12'hbb8, 12'hce4, 12'he10, 12'hfa0};

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS        = 40;
  localparam int unsigned MONITOR_IRQ_DELAY_NS = 60000;
  localparam int unsigned MONITOR_IRQ_DELAY_CYC =
    (MONITOR_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {MON_OFF, MON_HIGH, MON_WAIT, MON_LOW} irqlv_mon_e;

endpackage : irqlv_pkg

// [hdl/irqlv_edge_detect.sv]
// External pin edge detector with a two-bit edge select.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none

module irqlv_edge_detect
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] sel_i,
  output logic            edge_o
);

  logic prev_q;
  logic primed_q;

  // The first sample after reset only primes the history, so a pin that is
  // already high is not mistaken for a rising edge.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prev_q   <= 1'b0;
      primed_q <= 1'b0;
    end
    else
    begin
      prev_q   <= pin_i;
      primed_q <= 1'b1;
    end
  end

  always_comb
  begin
    edge_o = 1'b0;
    if (primed_q)
    begin
      unique case (sel_i)
        irqlv_pkg::EDGE_OFF:  edge_o = 1'b0;
        irqlv_pkg::EDGE_RISE: edge_o = pin_i & ~prev_q;
        irqlv_pkg::EDGE_FALL: edge_o = ~pin_i & prev_q;
        irqlv_pkg::EDGE_BOTH: edge_o = pin_i ^ prev_q;
      endcase
    end
  end

endmodule : irqlv_edge_detect
`default_nettype wire

// [hdl/irqlv_supply_monitor.sv]
// Low supply monitor: output flag and delayed request pulse.
// Assumes the analog comparator result arrives synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none

module irqlv_supply_monitor
#(
  parameter int unsigned DELAY_CYC = irqlv_pkg::MONITOR_IRQ_DELAY_CYC
)
(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic enable_i,
  input  wire logic sleep_i,
  input  wire logic below_i,
  output logic      on_o,
  output logic      flag_o,
  output logic      irq_o
);

  localparam int unsigned CW = $clog2(DELAY_CYC + 1);

  irqlv_pkg::irqlv_mon_e state_q;
  logic [CW-1:0]         count_q;
  logic                  active;

  assign active = enable_i & ~sleep_i;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= irqlv_pkg::MON_OFF;
      count_q <= '0;
      irq_o   <= 1'b0;
    end
    else
    begin
      irq_o <= 1'b0;
      if (!active)
        state_q <= irqlv_pkg::MON_OFF;
      else
      begin
        unique case (state_q)
          irqlv_pkg::MON_OFF, irqlv_pkg::MON_HIGH:
          begin
            count_q <= '0;
            state_q <= below_i ? irqlv_pkg::MON_WAIT : irqlv_pkg::MON_HIGH;
          end
          irqlv_pkg::MON_WAIT:
          begin
            // Each dip restarts the wait; no filtering of the flag itself.
            if (!below_i)
              state_q <= irqlv_pkg::MON_HIGH;
            else if (count_q == CW'(DELAY_CYC - 1))
            begin
              irq_o   <= 1'b1;
              state_q <= irqlv_pkg::MON_LOW;
            end
            else
              count_q <= count_q + 1'b1;
          end
          irqlv_pkg::MON_LOW:
            if (!below_i)
              state_q <= irqlv_pkg::MON_HIGH;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      on_o   <= 1'b0;
      flag_o <= 1'b0;
    end
    else
    begin
      on_o   <= active;
      flag_o <= active & below_i;
    end
  end

endmodule : irqlv_supply_monitor
`default_nettype wire

// [bench/irqlv_top_asserts.sv]
// Checker for the interrupt and supply monitor block, bound to its top module.
// Assumes only the top's ports; register contents are shadowed from port writes.
`timescale 1ns/1ns
`default_nettype none
module irqlv_top_asserts
#(
  parameter int unsigned MONITOR_DELAY_CYC = 4
)
(
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic [2:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        sleep_i,
  input wire logic        idle_i,
  input wire logic        supply_below_i,
  input wire logic        irq_req_o,
  input wire logic        wake_o,
  input wire logic        supply_monitor_on_o,
  input wire logic [11:0] supply_threshold_mv_o
);
  // ************************************************************
  // Shadow state
  // ************************************************************
  localparam logic [11:0] MV [8] = '{12'h708, 12'h7d0, 12'h960, 12'ha8c, 12'hbb8, 12'hce4, 12'he10, 12'hfa0};
  logic       glob_q;
  logic [2:0] sel_q;
  logic [2:0] quiet_q;
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) glob_q <= 1'b0;
    else if (sfr_wr_i && sfr_addr_i == irqlv_pkg::REG_PRIM0) glob_q <= sfr_wdata_i[0];
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) sel_q <= 3'h0;
    else if (sfr_wr_i && sfr_addr_i == irqlv_pkg::REG_MONITOR) sel_q <= sfr_wdata_i[2:0];
  // The flag passes through flops, so only a long quiet spell proves it must be low.
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) quiet_q <= 3'h0;
    else if (supply_below_i && !sleep_i) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  edge_upper_zero_a: assert property (sfr_rd_i && sfr_addr_i == irqlv_pkg::REG_EDGE |=>
    sfr_rdata_o[7:4] == 4'h0) else $error("edge select upper bits not zero");
  prim_top_zero_a: assert property (sfr_rd_i && sfr_addr_i == irqlv_pkg::REG_PRIM0 |=>
    !sfr_rdata_o[7]) else $error("primary zero bit 7 not zero");
  unmapped_zero_a: assert property (sfr_rd_i && sfr_addr_i == 3'h7 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  sleep_off_a: assert property (sleep_i [*3] |-> !supply_monitor_on_o)
    else $error("monitor on during sleep");
  global_gate_a: assert property (!glob_q && !$past(glob_q) && !$past(glob_q, 2) |-> !irq_req_o)
    else $error("request without global enable");
  wake_mode_a: assert property (wake_o |-> $past(sleep_i) || $past(idle_i) ||
    $past(sleep_i, 2) || $past(idle_i, 2)) else $error("wake outside sleep or idle");
  thresh_map_a: assert property (sel_q == $past(sel_q) && sel_q == $past(sel_q, 2) |->
    supply_threshold_mv_o == MV[sel_q]) else $error("threshold does not match select");
  flag_quiet_a: assert property (quiet_q == 3'h7 && sfr_rd_i && sfr_addr_i == irqlv_pkg::REG_MONITOR |=>
    !sfr_rdata_o[5]) else $error("low supply flag set while supply fine");
endmodule : irqlv_top_asserts
bind irqlv_top irqlv_top_asserts #(.MONITOR_DELAY_CYC(MONITOR_DELAY_CYC)) u_asserts (
  .clock_i(clock_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sleep_i(sleep_i),
  .idle_i(idle_i), .supply_below_i(supply_below_i), .irq_req_o(irq_req_o), .wake_o(wake_o),
  .supply_monitor_on_o(supply_monitor_on_o), .supply_threshold_mv_o(supply_threshold_mv_o));
`default_nettype wire

// [bench/irqlv_top_tb.sv]
// Self-checking bench for the interrupt and supply monitor block.
// Assumes the package and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module irqlv_top_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int unsigned DLY = 4;
  localparam logic [7:0] LOC [14] = '{8'h25, 8'h45, 8'h36, 8'h37, 8'h35, 8'h46, 8'h47,
                                      8'h54, 8'h55, 8'h56, 8'h57, 8'h64, 8'h65, 8'h67};
  localparam logic [7:0] RB [8] = '{8'h17, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [1:0]  pin = 2'h0;
  logic [13:0] evt = 14'h0;
  logic        below = 1'b0;
  logic        sleep = 1'b0;
  logic        idle = 1'b0;
  logic        ack = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic [3:0]  vec;
  logic        wake;
  logic        mon_on;
  logic [11:0] mv;
  logic [7:0]  d;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  irqlv_top #(.MONITOR_DELAY_CYC(DLY)) DUT (
    .clock_i(clk), .resetn_i(rstn), .sfr_addr_i(addr), .sfr_wr_i(wr_en), .sfr_rd_i(rd_en),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .external_irq_pin_i(pin), .comparator_evt_i(evt[1:0]),
    .time_base_evt_i(evt[3:2]), .adc_evt_i(evt[4]), .usim_evt_i(evt[5]), .uart_evt_i(evt[6]),
    .timer_group0_evt_i(evt[10:7]), .timer_group1_evt_i(evt[12:11]), .eeprom_evt_i(evt[13]),
    .supply_below_i(below), .sleep_i(sleep), .idle_i(idle), .irq_ack_i(ack), .irq_req_o(irq),
    .irq_vector_o(vec), .wake_o(wake), .supply_monitor_on_o(mon_on), .supply_threshold_mv_o(mv));
  always #20 clk = ~clk;
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Sampling 1 ns after the edge keeps checks clear of the edge's own updates.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt[i] <= 1'b0;
  endtask : pulse
  task automatic ack_once();
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    tick(3);
  endtask : ack_once
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    chk(mv, 12'h708);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a));
      chk({4'h0, d}, 12'h000);
    end
    for (int a = 0; a < 8; a++)
      wr(3'(a), 8'hff);
    tick(3);
    chk(mv, 12'hfa0);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a));
      chk({4'h0, d}, {4'h0, RB[a]});
    end
    for (int a = 7; a >= 0; a--)
      wr(3'(a), 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      wr(irqlv_pkg::REG_MONITOR, 8'(s));
      tick(2);
      chk(mv, irqlv_pkg::THRESH_MV[s]);
    end
  endtask : t_regs
  task automatic t_events();
    for (int i = 0; i < 14; i++)
    begin
      pulse(i);
      tick(2);
      rd(LOC[i][6:4]);
      chk({11'h0, d[LOC[i][2:0]]}, 12'h001);
      chk({11'h0, irq}, 12'h000);
      wr(LOC[i][6:4], 8'h00);
    end
  endtask : t_events
  task automatic t_edges();
    logic [2:0] r;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        r = (p == 0) ? irqlv_pkg::REG_PRIM0 : irqlv_pkg::REG_PRIM2;
        wr(irqlv_pkg::REG_EDGE, 8'(c << (2 * p)));
        for (int e = 0; e < 2; e++)
        begin
          wr(r, 8'h00);
          @(posedge clk);
          pin[p] <= ~pin[p];
          tick(2);
          rd(r);
          chk({11'h0, d[4]}, {11'h0, c[e]});
        end
      end
  endtask : t_edges
  task automatic t_irq();
    wr(irqlv_pkg::REG_EDGE, 8'h01);
    wr(irqlv_pkg::REG_PRIM0, 8'h07);
    pulse(0);
    @(posedge clk);
    pin[0] <= 1'b1;
    tick(3);
    chk({11'h0, irq}, 12'h001);
    chk({8'h0, vec}, 12'h000);
    ack_once();
    chk({8'h0, vec}, 12'h001);
    ack_once();
    chk({11'h0, irq}, 12'h000);
    wr(irqlv_pkg::REG_PRIM0, 8'h06);
    pulse(0);
    tick(3);
    chk({11'h0, irq}, 12'h000);
    rd(irqlv_pkg::REG_PRIM0);
    chk({4'h0, d}, 12'h026);
    wr(irqlv_pkg::REG_EDGE, 8'h00);
    @(posedge clk);
    pin[0] <= 1'b0;
    wr(irqlv_pkg::REG_PRIM0, 8'h00);
  endtask : t_irq
  task automatic t_group();
    wr(irqlv_pkg::REG_GROUP0, 8'h01);
    wr(irqlv_pkg::REG_PRIM0, 8'h08);
    pulse(8);
    tick(3);
    rd(irqlv_pkg::REG_PRIM0);
    chk({4'h0, d}, 12'h008);
    pulse(7);
    tick(3);
    rd(irqlv_pkg::REG_PRIM0);
    chk({4'h0, d}, 12'h048);
    rd(irqlv_pkg::REG_GROUP0);
    chk({4'h0, d}, 12'h031);
    wr(irqlv_pkg::REG_GROUP0, 8'h00);
    wr(irqlv_pkg::REG_PRIM0, 8'h00);
  endtask : t_group
  task automatic t_supply();
    wr(irqlv_pkg::REG_MONITOR, 8'h13);
    tick(3);
    chk(mv, 12'ha8c);
    chk({11'h0, mon_on}, 12'h001);
    @(posedge clk);
    below <= 1'b1;
    rd(irqlv_pkg::REG_GROUP1);
    chk({11'h0, d[6]}, 12'h000);
    rd(irqlv_pkg::REG_MONITOR);
    chk({11'h0, d[5]}, 12'h001);
    for (int i = 0; i < 10 && d[6] !== 1'b1; i++)
      rd(irqlv_pkg::REG_GROUP1);
    chk({11'h0, d[6]}, 12'h001);
    rd(irqlv_pkg::REG_PRIM1);
    chk({4'h0, d}, 12'h000);
    @(posedge clk);
    below <= 1'b0;
    rd(irqlv_pkg::REG_MONITOR);
    chk({11'h0, d[5]}, 12'h000);
    @(posedge clk);
    sleep <= 1'b1;
    below <= 1'b1;
    tick(3);
    chk({11'h0, mon_on}, 12'h000);
    rd(irqlv_pkg::REG_MONITOR);
    chk({11'h0, d[5]}, 12'h000);
    @(posedge clk);
    sleep <= 1'b0;
    below <= 1'b0;
  endtask : t_supply
  task automatic t_idle(input logic [7:0] pre, input logic exp);
    logic got;
    got = 1'b0;
    wr(irqlv_pkg::REG_GROUP1, pre);
    @(posedge clk);
    idle <= 1'b1;
    below <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      tick(1);
      got = got | (wake === 1'b1);
    end
    chk({11'h0, got}, {11'h0, exp});
    rd(irqlv_pkg::REG_GROUP1);
    chk({11'h0, d[6]}, 12'h001);
    @(posedge clk);
    idle <= 1'b0;
    below <= 1'b0;
    tick(4);
  endtask : t_idle
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_events();
    t_edges();
    t_irq();
    t_group();
    t_supply();
    t_idle(8'h00, 1'b1);
    t_idle(8'h40, 1'b0);
    summarize();
  end
endmodule : irqlv_top_tb
`default_nettype wire
